// *** rtl/sar_map.svh ***
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name from rtl/ sources, definitions only
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

// register byte offsets
`define OFS_INPUT_SELECT 4'h0
`define OFS_CTRL_STATUS  4'h4
`define OFS_RESULT_LOW   4'h8
`define OFS_RESULT_HIGH  4'hC

// input_select_register fields
`define SEL_REF_MSB      7
`define SEL_REF_LSB      6
`define SEL_LEFT_BIT     5
`define SEL_CHAN_MSB     3
`define SEL_CHAN_LSB     0

// converter_control_status fields
`define CS_ENABLE_BIT    7
`define CS_START_BIT     6
`define CS_FREE_BIT      5
`define CS_FLAG_BIT      4
`define CS_IE_BIT        3
`define CS_PS_MSB        2
`define CS_PS_LSB        0

// reset values
`define RST_SEL          6'h00
`define RST_PS           3'h0
`define RST_RESULT       10'h000

// conversion timing in converter clock cycles
`define CONV_CYC_NORMAL  5'd13
`define CONV_CYC_FIRST   5'd25
`define SAMPLE_NORMAL    5'd1
`define SAMPLE_FIRST     5'd13
`define SAR_MSB_MASK     10'h200

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** rtl/sar_pkg.sv ***
// types shared by the converter sequencer and its bench
// assumes: compiled before every other rtl file
`default_nettype none

package sar_pkg;

  // sequencer states, gray along idle -> armed -> converting
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ARMED = 2'h1,
    ST_CONV  = 2'h3
  } seq_state_t;

  // selection presented to the analog multiplexer
  typedef struct packed {
    logic [1:0] reference_select;
    logic [3:0] channel_select;
  } mux_sel_t;

endpackage

`default_nettype wire

// *** rtl/sar_prescaler.sv ***
// converter clock prescaler: one-cycle rise and fall enables
// assumes: single aclk domain, run low keeps the divider in reset
`default_nettype none

module sar_prescaler #(
  parameter int PS_W  = 3,
  parameter int CNT_W = 7
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             run,
  input  wire logic [PS_W-1:0]  sel,
  // converter clock edges
  output logic                  rise,
  output logic                  fall
);

  // the counter must reach the largest ratio
  if (CNT_W < (1 << PS_W) - 1) begin : g_bad_width
    $error("prescaler counter too narrow for the ratio field");
  end

  logic [CNT_W-1:0] count_q;
  logic [CNT_W:0]   pow;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] half;

  // ratios 2,2,4,...,128: code zero doubles up on 2
  assign pow  = (CNT_W+1)'(1) << sel;
  assign last = (sel == '0) ? CNT_W'(1) : CNT_W'(pow - (CNT_W+1)'(1));
  assign half = last >> 1;
  assign rise = run && (count_q == last);
  assign fall = run && (count_q == half);

  // divider, held at zero while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_q <= '0;
    end else if (count_q >= last) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CNT_W'(1);
    end
  end

endmodule

`default_nettype wire

// *** rtl/sar_converter_sequencer.sv ***
// converter sequencer: axi4-lite registers, prescaler, sar sequencing
// assumes: one aclk domain, comparator answer synchronous to aclk
// Notes on behaviour
// - ten-bit code by successive approximation, zero is ground
// - channel field picks input pin, ground or bandgap
// - reference and channel reach the converter only while enabled
// - result right aligned, left aligned when left-align bit set
// - reading low byte locks result until high byte is read
// - done flag still sets when a locked result is dropped
// - start bit begins conversion, reads one, single mode clears it
// - channel change mid-conversion applies after current conversion
// - free running restarts at once, start stays high
// - prescaler divides by selected ratio, reset while disabled
// - conversion begins at next converter clock rising edge
// - normal conversion 13 cycles, first after enable 25
// - sample-and-hold at 1.5 cycles, or 13.5 on first conversion
// - result stored and done flag set in the same step
// - selection held during conversion, reloads in last cycle
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`default_nettype none
`include "sar_map.svh"

module sar_converter_sequencer #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic            awvalid,
  output logic                 awready,
  input  wire logic [31:0]     wdata,
  input  wire logic [3:0]      wstrb,
  input  wire logic            wvalid,
  output logic                 wready,
  output logic [1:0]           bresp,
  output logic                 bvalid,
  input  wire logic            bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic            arvalid,
  output logic                 arready,
  output logic [31:0]          rdata,
  output logic [1:0]           rresp,
  output logic                 rvalid,
  input  wire logic            rready,
  // interrupt
  output logic                 irq,
  input  wire logic            irq_ack,
  // analog front end
  output sar_pkg::mux_sel_t    analog_sel,
  output logic                 analog_on,
  output logic                 sample_hold,
  output logic [9:0]           trial_code,
  input  wire logic            comp_keep
);
  import sar_pkg::*;

  if (ADDR_W < 4) begin : g_bad_addr
    $error("address too narrow for the register map");
  end

  // ------------------------------------------------------------
  // register decode
  // ------------------------------------------------------------

  // one decode shared by the read and write paths
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    logic [3:0] o;
    o = a[3:0];
    if ((a >> 4) != '0) begin
      return 1'b0;
    end else if (o == `OFS_INPUT_SELECT) begin
      return 1'b1;
    end else if (o == `OFS_CTRL_STATUS) begin
      return 1'b1;
    end else if (o == `OFS_RESULT_LOW) begin
      return 1'b1;
    end else if (o == `OFS_RESULT_HIGH) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic              aw_got_q, w_got_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q;
  logic              wr_fire, wr_sel, wr_ctrl, rd_fire, rd_low, rd_high;

  // control and status state
  logic [1:0]        ref_q;
  logic [3:0]        chan_q;
  logic              left_q, en_q, start_q, free_q, flag_q, ie_q;
  logic [2:0]        ps_q;
  logic [9:0]        raw_q;
  logic              lock_q, long_q, first_q, irq_q;
  seq_state_t        state_q;
  logic [4:0]        cyc_q;
  logic [9:0]        sar_q, mask_q, trial_q;
  mux_sel_t          hold_q;
  logic              on_q, sh_q;
  logic              rise, fall, done_now;
  logic [4:0]        last_cyc, samp_cyc;
  logic [7:0]        lo_byte, hi_byte;

  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign wr_sel  = wr_fire && wlane_q && (waddr_q == ADDR_W'(`OFS_INPUT_SELECT));
  assign wr_ctrl = wr_fire && wlane_q && (waddr_q == ADDR_W'(`OFS_CTRL_STATUS));
  assign rd_fire = arvalid && arready_q;
  assign rd_low  = rd_fire && (araddr == ADDR_W'(`OFS_RESULT_LOW));
  assign rd_high = rd_fire && (araddr == ADDR_W'(`OFS_RESULT_HIGH));

  // ------------------------------------------------------------
  // axi4-lite slave
  // ------------------------------------------------------------

  // write address and data are taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b0;
      waddr_q   <= '0;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      waddr_q   <= awaddr;
    end else if (wr_fire) begin
      aw_got_q  <= 1'b0;
    end else if (!aw_got_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b0;
      wbyte_q  <= '0;
      wlane_q  <= 1'b0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      wbyte_q  <= wdata[7:0];
      wlane_q  <= wstrb[0];
    end else if (wr_fire) begin
      w_got_q  <= 1'b0;
    end else if (!w_got_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= addr_ok(waddr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // result bytes formatted at read time from the stored code
  // alignment select
  assign lo_byte = left_q ? {raw_q[1:0], 6'h00} : raw_q[7:0];
  assign hi_byte = left_q ? raw_q[9:2] : {6'h00, raw_q[9:8]};

  // read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= `RESP_OKAY;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= addr_ok(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      if (araddr == ADDR_W'(`OFS_INPUT_SELECT)) begin
        rdata_q <= {24'h000000, ref_q, left_q, 1'b0, chan_q};
      end else if (araddr == ADDR_W'(`OFS_CTRL_STATUS)) begin
        rdata_q <= {24'h000000, en_q, start_q, free_q, flag_q, ie_q, ps_q};
      end else if (araddr == ADDR_W'(`OFS_RESULT_LOW)) begin
        rdata_q <= {24'h000000, lo_byte};
      end else if (araddr == ADDR_W'(`OFS_RESULT_HIGH)) begin
        rdata_q <= {24'h000000, hi_byte};
      end else begin
        rdata_q <= '0;
      end
    end else if (rvalid_q && rready) begin
      rvalid_q  <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------

  // input selection, free to change at any time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ref_q, chan_q} <= `RST_SEL;
      left_q          <= 1'b0;
    end else if (wr_sel) begin
      ref_q  <= wbyte_q[`SEL_REF_MSB:`SEL_REF_LSB];
      left_q <= wbyte_q[`SEL_LEFT_BIT];
      chan_q <= wbyte_q[`SEL_CHAN_MSB:`SEL_CHAN_LSB];
    end
  end

  // plain control bits
  // three-bit ratio field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q   <= 1'b0;
      free_q <= 1'b0;
      ie_q   <= 1'b0;
      ps_q   <= `RST_PS;
    end else if (wr_ctrl) begin
      en_q   <= wbyte_q[`CS_ENABLE_BIT];
      free_q <= wbyte_q[`CS_FREE_BIT];
      ie_q   <= wbyte_q[`CS_IE_BIT];
      ps_q   <= wbyte_q[`CS_PS_MSB:`CS_PS_LSB];
    end
  end

  // start bit: a new write wins over the clear at completion
  // start and self-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q <= 1'b0;
    end else if (wr_ctrl && wbyte_q[`CS_START_BIT] && wbyte_q[`CS_ENABLE_BIT]) begin
      start_q <= 1'b1;
    end else if (!en_q) begin
      start_q <= 1'b0;
    end else if (done_now && !free_q) begin
      start_q <= 1'b0;
    end
  end

  // done flag: hardware set beats a clear in the same cycle
  // sets even when dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (done_now) begin
      flag_q <= 1'b1;
    end else if ((wr_ctrl && wbyte_q[`CS_FLAG_BIT]) || irq_ack) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= flag_q && ie_q;
    end
  end

  // ------------------------------------------------------------
  // result bytes and read lock
  // ------------------------------------------------------------

  // low read locks, high read frees
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (rd_high) begin
      lock_q <= 1'b0;
    end else if (rd_low) begin
      lock_q <= 1'b1;
    end
  end

  // a code finished while locked is dropped
  // store with the flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_q <= `RST_RESULT;
    end else if (done_now && !lock_q) begin
      raw_q <= sar_q;
    end
  end

  // ------------------------------------------------------------
  // conversion sequencing
  // ------------------------------------------------------------

  sar_prescaler #(
    .PS_W  (3),
    .CNT_W (7)
  ) u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (en_q),
    .sel     (ps_q),
    .rise    (rise),
    .fall    (fall)
  );

  assign last_cyc = long_q ? `CONV_CYC_FIRST - 5'd1 : `CONV_CYC_NORMAL - 5'd1;
  assign samp_cyc = long_q ? `SAMPLE_FIRST : `SAMPLE_NORMAL;
  assign done_now = (state_q == ST_CONV) && rise && (cyc_q == last_cyc);

  // first conversion after switching on is the long one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= 1'b0;
    end else if (wr_ctrl && wbyte_q[`CS_ENABLE_BIT] && !en_q) begin
      first_q <= 1'b1;
    end else if (state_q == ST_ARMED && rise) begin
      first_q <= 1'b0;
    end
  end

  // start waits for a converter clock rise
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_q) begin
      state_q <= ST_IDLE;
      cyc_q   <= '0;
      long_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_q) begin
            state_q <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (rise) begin
            state_q <= ST_CONV;
            cyc_q   <= '0;
            long_q  <= first_q;
          end
        end
        ST_CONV: begin
          if (done_now) begin
            cyc_q   <= '0;
            long_q  <= 1'b0;
            state_q <= free_q ? ST_CONV : ST_IDLE;
          end else if (rise) begin
            cyc_q <= cyc_q + 5'd1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sample half a cycle into the sample cycle
  // one bit per cycle, msb first
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_CONV) begin
      sar_q   <= '0;
      mask_q  <= '0;
      trial_q <= '0;
      sh_q    <= 1'b0;
    end else begin
      sh_q <= fall && (cyc_q == samp_cyc);
      if (done_now) begin
        sar_q   <= '0;
        mask_q  <= '0;
        trial_q <= '0;
      end else if (fall && cyc_q == samp_cyc) begin
        sar_q   <= '0;
        mask_q  <= `SAR_MSB_MASK;
        trial_q <= `SAR_MSB_MASK;
      end else if (rise && cyc_q > samp_cyc && mask_q != '0) begin
        sar_q   <= comp_keep ? trial_q : sar_q;
        mask_q  <= mask_q >> 1;
        trial_q <= (comp_keep ? trial_q : sar_q) | (mask_q >> 1);
      end
    end
  end

  // selection frozen from the first conversion cycle to the final cycle
  // new channel waits for the next conversion
  // nothing reaches the converter while disabled
  // channel code passed to the multiplexer
  always_ff @(posedge aclk) begin
    if (!aresetn || !en_q) begin
      hold_q <= '0;
      on_q   <= 1'b0;
    end else begin
      on_q <= 1'b1;
      if (state_q != ST_CONV || cyc_q == last_cyc) begin
        hold_q <= '{reference_select: ref_q, channel_select: chan_q};
      end
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign awready     = awready_q;
  assign wready      = wready_q;
  assign bvalid      = bvalid_q;
  assign bresp       = bresp_q;
  assign arready     = arready_q;
  assign rvalid      = rvalid_q;
  assign rdata       = rdata_q;
  assign rresp       = rresp_q;
  assign irq         = irq_q;
  assign analog_sel  = hold_q;
  assign analog_on   = on_q;
  assign sample_hold = sh_q;
  assign trial_code  = trial_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_armed_rise;
    (state_q == ST_ARMED) && en_q ##0 rise;
  endsequence

  property p_start_edge;
    s_armed_rise |=> (state_q == ST_CONV) && (cyc_q == 5'd0);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("start missed clock rise");

  property p_store;
    done_now && !lock_q |=> flag_q && (raw_q == $past(sar_q));
  endproperty
  a_store: assert property (p_store) else $error("result and flag not together");

  property p_locked_drop;
    done_now && lock_q |=> flag_q && $stable(raw_q);
  endproperty
  a_locked_drop: assert property (p_locked_drop) else $error("locked result changed");

  property p_single_clear;
    done_now && !free_q && !wr_ctrl |=> !start_q && (state_q == ST_IDLE);
  endproperty
  a_single_clear: assert property (p_single_clear) else $error("start not cleared");

  property p_free_restart;
    done_now && free_q && en_q && !wr_ctrl |=> start_q && (state_q == ST_CONV) && (cyc_q == 5'd0);
  endproperty
  a_free_restart: assert property (p_free_restart) else $error("no free restart");

  property p_held_div;
    !en_q |-> !rise && !fall ##1 (u_prescaler.count_q == 7'h00);
  endproperty
  a_held_div: assert property (p_held_div) else $error("prescaler ran while off");

  property p_length;
    done_now |-> (cyc_q == (long_q ? 5'd24 : 5'd12));
  endproperty
  a_length: assert property (p_length) else $error("wrong conversion length");

  property p_sample;
    sample_hold |-> $past(fall) && ($past(cyc_q) == ($past(long_q) ? 5'd13 : 5'd1));
  endproperty
  a_sample: assert property (p_sample) else $error("sample point misplaced");

  property p_frozen;
    (state_q == ST_CONV) && $past(state_q == ST_CONV) && ($past(cyc_q) != $past(last_cyc))
      && en_q && $past(en_q) |-> $stable(analog_sel);
  endproperty
  a_frozen: assert property (p_frozen) else $error("selection moved mid conversion");

  property p_irq;
    ##1 1'b1 |-> irq == $past(flag_q && ie_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule

`default_nettype wire

// *** sim/sar_front_model.sv ***
// analog front end model: channel levels, sample capture, comparator
// assumes: driven by the sequencer's analog outputs on aclk
`default_nettype none

module sar_front_model (
  // clock
  input  wire logic              aclk,
  // from the sequencer
  input  wire sar_pkg::mux_sel_t analog_sel,
  input  wire logic              analog_on,
  input  wire logic              sample_hold,
  input  wire logic [9:0]        trial_code,
  // comparator answer
  output logic                   comp_keep
);
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;

  logic [9:0] held_q;
  logic       noise_q = 1'b0;

  // hold the selected channel level at the sample pulse
  always @(posedge aclk) begin
    noise_q <= ~noise_q;
    if (sample_hold) begin
      held_q <= {analog_sel.channel_select, 6'h2B};
    end
  end

  // keep bit when held input reaches trial; noise while powered off
  assign comp_keep = analog_on ? (held_q >= trial_code) : noise_q;
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for the converter sequencer over axi4-lite
// assumes: front end model answers comp_keep combinationally
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sar_pkg::*;

  localparam int LIMIT = 20000;
  localparam int RATIO = 4; // fast converter clock, resolution not judged here

  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  awaddr  = 5'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic [4:0]  araddr  = 5'h00;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        irq_ack = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  mux_sel_t    analog_sel;
  logic        analog_on, sample_hold, comp_keep;
  logic [9:0]  trial_code;
  int          bad_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          last_sh = 0;
  int          gap = 0;
  logic [1:0]  wresp = 2'h0;

  sar_converter_sequencer #(.ADDR_W(5)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq), .irq_ack(irq_ack),
    .analog_sel(analog_sel), .analog_on(analog_on), .sample_hold(sample_hold),
    .trial_code(trial_code), .comp_keep(comp_keep)
  );

  sar_front_model front (
    .aclk(aclk), .analog_sel(analog_sel), .analog_on(analog_on),
    .sample_hold(sample_hold), .trial_code(trial_code), .comp_keep(comp_keep)
  );

  // ----------------------------------------
  // clock, spacing monitor, watchdog
  // ----------------------------------------
  always #4 aclk = ~aclk;

  // sample spacing shows conversion length in free running
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (sample_hold) begin
      last_sh <= cyc;
      gap <= cyc - last_sh;
    end
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons = comparisons + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic ta;
    logic tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ta && tw));
    do @(posedge aclk); while (bvalid !== 1'b1);
    wresp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // poll status until the done flag shows
  task automatic wait_flag();
    logic [31:0] d;
    logic [1:0]  r;
    do rd(5'h04, d, r); while (d[4] !== 1'b1);
  endtask

  function automatic logic [9:0] lvl(input logic [3:0] c);
    return {c, 6'h2B};
  endfunction

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [9:0]  l3, l5, l9;
    l3 = lvl(4'h3);
    l5 = lvl(4'h5);
    l9 = lvl(4'h9);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(5'h04, d, r);
    chk("ctrl reset", d, 32'h0);
    rd(5'h10, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    wr(5'h10, 8'hFF);
    chk("unmapped wr resp", {30'h0, wresp}, 32'h2);
    $display("test reset done");

    wr(5'h00, 8'h03);
    chk("wr resp", {30'h0, wresp}, 32'h0);
    chk("sel while off", {26'h0, analog_sel}, 32'h0);
    chk("front off", {31'h0, analog_on}, 32'h0);
    wr(5'h04, 8'h8A);
    repeat (2) @(posedge aclk);
    chk("sel when on", {26'h0, analog_sel}, 32'h03);
    chk("front on", {31'h0, analog_on}, 32'h1);
    wr(5'h04, 8'hCA);
    rd(5'h04, d, r);
    chk("start busy", {31'h0, d[6]}, 32'h1);
    wr(5'h00, 8'h09);
    wait_flag();
    rd(5'h04, d, r);
    chk("ctrl done", d, 32'h9A);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(5'h08, d, r);
    chk("low right", d, {24'h0, l3[7:0]});
    rd(5'h0C, d, r);
    chk("high right", d, {30'h0, l3[9:8]});
    $display("test single done");

    wr(5'h00, 8'h29);
    wr(5'h04, 8'hDA);
    wait_flag();
    rd(5'h0C, d, r);
    chk("high left", d, {24'h0, l9[9:2]});
    rd(5'h08, d, r);
    chk("low left", d, {24'h0, l9[1:0], 6'h0});
    rd(5'h0C, d, r);
    $display("test align done");

    @(posedge aclk);
    irq_ack <= 1'b1;
    @(posedge aclk);
    irq_ack <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("irq acked", {31'h0, irq}, 32'h0);
    wr(5'h00, 8'h03);
    rd(5'h08, d, r);
    wr(5'h04, 8'hCA);
    wait_flag();
    rd(5'h0C, d, r);
    chk("high locked", d, {30'h0, l9[9:8]});
    wr(5'h04, 8'hDA);
    wait_flag();
    rd(5'h08, d, r);
    chk("low unlocked", d, {24'h0, l3[7:0]});
    rd(5'h0C, d, r);
    $display("test lock done");

    wr(5'h00, 8'h05);
    wr(5'h04, 8'hFA);
    wait_flag();
    wr(5'h04, 8'hBA);
    wait_flag();
    rd(5'h04, d, r);
    chk("start free", {31'h0, d[6]}, 32'h1);
    chk("sample gap", gap, 13 * RATIO);
    rd(5'h08, d, r);
    chk("low free", d, {24'h0, l5[7:0]});
    rd(5'h0C, d, r);
    $display("test free done");

    wr(5'h04, 8'h00);
    rd(5'h04, d, r);
    chk("start off", {31'h0, d[6]}, 32'h0);
    repeat (2) @(posedge aclk);
    chk("sel off", {26'h0, analog_sel}, 32'h0);
    chk("front off late", {31'h0, analog_on}, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    $display("test disable done");
    stop_test();
  end
endmodule

`default_nettype wire
